// *** logic/fod_filter_cfg.sv ***
`timescale 1ns/1ns
// Overview of operation
// - five-bit filter field, read/write, resets zero
// - five filter structures selectable
// - codes 0-7 wideband, ratio 32 to 4096
// - codes 8-18 lone sinc4, ratio 12-4096
// - codes 19-27 sinc4 32 plus averager
// - codes 28,29 sinc3 at 26667 or 32000
// - codes 30,31 sinc3 32000 plus averager 3/5
// - second config register at index 8, reset zero
// - clock/drive/integrity fields, bit 4 reads zero
// - clock source select, external divide by eight
// - resolution bit picks 24 or 16 bits
// - serial check mismatch flag, write one clears
// - filter field at index 7 under delay
module fod_filter_cfg
  import fod_pkg::*;
#(
  parameter int INT_DIV = FOD_INT_DIV
)(
  input  wire logic                    CLOCK,
  input  wire logic                    RESETN,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [FOD_ADDR_W-1:0]   PADDR,
  input  wire logic [FOD_DATA_W-1:0]   PWDATA,
  input  wire logic [3:0]              PSTRB,
  output logic      [FOD_DATA_W-1:0]   PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    EXT_CLK,
  input  wire logic [FOD_SAMPLE_W-1:0] SAMPLE_IN,
  input  wire logic                    CRC_CHECK,
  input  wire logic [7:0]              CRC_RX,
  input  wire logic [7:0]              CRC_CALC,
  output fod_filt_s                    FILTER_CFG,
  output logic      [FOD_DLY_W-1:0]    START_DELAY,
  output logic                         MOD_EN,
  output logic                         DATA_READY,
  output logic      [FOD_SAMPLE_W-1:0] CONV_DATA,
  output logic                         CONV_16BIT,
  output logic      [7:0]              STATUS_BYTE,
  output logic                         STATUS_BYTE_EN,
  output logic                         SERIAL_CRC_EN,
  output logic                         CRC_APPEND,
  output logic                         REG_CRC_EN,
  output logic                         OUTPUT_DRIVE_STRENGTH,
  output logic                         CLK_EXT_SEL,
  output logic                         CLK_DIV8
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]              filter_delay_config;
  logic [7:0]              clock_drive_integrity_config;
  logic                    serial_err;
  logic [5:0]              idx;
  logic                    aligned;
  logic                    setup;
  logic                    access;
  logic                    wr_lane0;
  logic                    hit_filt;
  logic                    hit_clk;
  logic                    hit_fstat;
  logic                    hit_err;
  logic                    mapped;
  logic [FOD_DATA_W-1:0]   next_prdata;
  fod_filt_s               dec_cfg;
  logic                    mod_en;
  logic [FOD_MAIN_W-1:0]   cnt_main;
  logic [FOD_POST_W-1:0]   cnt_post;
  logic                    main_wrap;
  logic                    post_wrap;
  logic                    restart;
  logic                    crc_bad;

  // ----------------------------------------------------------------
  // apb address decode
  // ----------------------------------------------------------------
  assign idx      = PADDR[7:2];
  assign aligned  = (PADDR[1:0] == 2'h0);
  assign setup    = PSEL & ~PENABLE;
  assign access   = PSEL & PENABLE;
  assign wr_lane0 = access & PWRITE & PSTRB[0];

  always_comb
  begin
    hit_filt  = 1'b0;
    hit_clk   = 1'b0;
    hit_fstat = 1'b0;
    hit_err   = 1'b0;
    if (!aligned)
      hit_filt = 1'b0;
    else if (idx == FOD_IDX_FILT)
      hit_filt = 1'b1;
    else if (idx == FOD_IDX_CLK)
      hit_clk = 1'b1;
    else if (idx == FOD_IDX_FSTAT)
      hit_fstat = 1'b1;
    else if (idx == FOD_IDX_ERR)
      hit_err = 1'b1;
  end

  assign mapped = hit_filt | hit_clk | hit_fstat | hit_err;

  // zero wait states: the answer is prepared during setup
  assign PREADY = 1'b1;

  // ----------------------------------------------------------------
  // filter and delay register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      filter_delay_config <= FOD_FILT_RST;
    else if (wr_lane0 && hit_filt)
      filter_delay_config <= PWDATA[7:0];
  end

  // ----------------------------------------------------------------
  // clock, drive and integrity register
  // ----------------------------------------------------------------
  // the reserved bit is masked on write so it always reads zero
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      clock_drive_integrity_config <= FOD_CLK_RST;
    else if (wr_lane0 && hit_clk)
      clock_drive_integrity_config <= PWDATA[7:0] & FOD_CLK_WMASK;
  end

  // ----------------------------------------------------------------
  // serial check error flag
  // ----------------------------------------------------------------
  assign crc_bad = CRC_CHECK & SERIAL_CRC_EN & (CRC_RX != CRC_CALC);

  // a mismatch in the clearing cycle keeps the flag set
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      serial_err <= 1'b0;
    else if (crc_bad)
      serial_err <= 1'b1;
    else if (wr_lane0 && hit_err && PWDATA[FOD_ERR_SER])
      serial_err <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read data and error answer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_prdata = '0;
    if (hit_filt)
      next_prdata[7:0] = filter_delay_config;
    else if (hit_clk)
      next_prdata[7:0] = clock_drive_integrity_config;
    else if (hit_fstat)
    begin
      next_prdata[FOD_FS_POST +: FOD_POST_W] = FILTER_CFG.osr_post;
      next_prdata[FOD_FS_MAIN +: FOD_MAIN_W] = FILTER_CFG.osr_main;
      next_prdata[FOD_FS_MODE +: 3]          = FILTER_CFG.mode;
    end
    else if (hit_err)
      next_prdata[FOD_ERR_SER] = serial_err;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      PRDATA <= '0;
    else if (setup)
      PRDATA <= PWRITE ? '0 : next_prdata;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      PSLVERR <= 1'b0;
    else if (setup)
      PSLVERR <= ~mapped;
    else if (access)
      PSLVERR <= 1'b0;
  end

  // ----------------------------------------------------------------
  // filter structure decode
  // ----------------------------------------------------------------
  fod_osr_decode u_decode
  (
    .code (filter_delay_config[FOD_FILT_LSB +: FOD_FILT_W]),
    .cfg  (dec_cfg)
  );

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      FILTER_CFG.mode     <= FOD_WIDEBAND;
      FILTER_CFG.osr_main <= '0;
      FILTER_CFG.osr_post <= '0;
    end
    else
      FILTER_CFG <= dec_cfg;
  end

  // ----------------------------------------------------------------
  // modulator clock enable
  // ----------------------------------------------------------------
  fod_mod_clock #(
    .INT_DIV (INT_DIV)
  ) u_clock
  (
    .clock   (CLOCK),
    .resetn  (RESETN),
    .ext_pin (EXT_CLK),
    .ext_sel (CLK_EXT_SEL),
    .div8    (CLK_DIV8),
    .mod_en  (mod_en)
  );

  assign MOD_EN = mod_en;

  // ----------------------------------------------------------------
  // decimation timing
  // ----------------------------------------------------------------
  // a new filter code restarts both stages so no partial frame leaks
  assign restart   = wr_lane0 & hit_filt;
  assign main_wrap = mod_en && (cnt_main == FILTER_CFG.osr_main - 1'b1);
  assign post_wrap = main_wrap &&
                     (cnt_post == FILTER_CFG.osr_post - 1'b1);

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      cnt_main <= '0;
    else if (restart || main_wrap)
      cnt_main <= '0;
    else if (mod_en)
      cnt_main <= cnt_main + 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      cnt_post <= '0;
    else if (restart || post_wrap)
      cnt_post <= '0;
    else if (main_wrap)
      cnt_post <= cnt_post + 1'b1;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      DATA_READY <= 1'b0;
    else
      DATA_READY <= post_wrap & ~restart;
  end

  // ----------------------------------------------------------------
  // conversion output word
  // ----------------------------------------------------------------
  // short words keep the top bits, low byte forced to zero
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      CONV_DATA <= '0;
    else if (post_wrap && CONV_16BIT)
      CONV_DATA <= {SAMPLE_IN[FOD_SAMPLE_W-1 -: FOD_SHORT_W],
                    8'h00};
    else if (post_wrap)
      CONV_DATA <= SAMPLE_IN;
  end

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      STATUS_BYTE <= 8'h00;
    else if (post_wrap)
      STATUS_BYTE <= {7'h00, serial_err};
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  assign START_DELAY           = filter_delay_config[FOD_DLY_LSB +: FOD_DLY_W];
  assign CLK_EXT_SEL           = clock_drive_integrity_config[FOD_CLK_SEL];
  assign CLK_DIV8              = clock_drive_integrity_config[FOD_CLK_DIV];
  assign OUTPUT_DRIVE_STRENGTH = clock_drive_integrity_config[FOD_DRIVE];
  assign CONV_16BIT            = clock_drive_integrity_config[FOD_RES16];
  assign SERIAL_CRC_EN         = clock_drive_integrity_config[FOD_SCRC];
  assign CRC_APPEND            = SERIAL_CRC_EN;
  assign REG_CRC_EN            = clock_drive_integrity_config[FOD_RCRC];
  assign STATUS_BYTE_EN        = clock_drive_integrity_config[FOD_STAT_EN];

endmodule

// *** logic/fod_pkg.sv ***
package fod_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int          FOD_DATA_W    = 32;
  localparam int          FOD_ADDR_W    = 8;
  localparam int          FOD_REG_W     = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0]  FOD_IDX_FILT  = 6'h07;
  localparam logic [5:0]  FOD_IDX_CLK   = 6'h08;
  localparam logic [5:0]  FOD_IDX_FSTAT = 6'h10;
  localparam logic [5:0]  FOD_IDX_ERR   = 6'h11;

  // ----------------------------------------------------------------
  // filter and delay register fields
  // ----------------------------------------------------------------
  localparam int          FOD_FILT_LSB  = 0;
  localparam int          FOD_FILT_W    = 5;
  localparam int          FOD_DLY_LSB   = 5;
  localparam int          FOD_DLY_W     = 3;
  localparam logic [7:0]  FOD_FILT_RST  = 8'h00;

  // ----------------------------------------------------------------
  // clock, drive and integrity register fields
  // ----------------------------------------------------------------
  localparam int          FOD_CLK_SEL   = 7;
  localparam int          FOD_CLK_DIV   = 6;
  localparam int          FOD_DRIVE     = 5;
  localparam int          FOD_RES16     = 3;
  localparam int          FOD_SCRC      = 2;
  localparam int          FOD_RCRC      = 1;
  localparam int          FOD_STAT_EN   = 0;
  localparam logic [7:0]  FOD_CLK_RST   = 8'h00;
  localparam logic [7:0]  FOD_CLK_WMASK = 8'hEF;

  // ----------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------
  localparam int          FOD_FS_POST   = 0;
  localparam int          FOD_FS_MAIN   = 10;
  localparam int          FOD_FS_MODE   = 25;
  localparam int          FOD_ERR_SER   = 0;

  // ----------------------------------------------------------------
  // clocking and data widths
  // ----------------------------------------------------------------
  localparam int          FOD_EXT_DIV   = 8;
  localparam int          FOD_INT_DIV   = 4;
  localparam int          FOD_SAMPLE_W  = 24;
  localparam int          FOD_SHORT_W   = 16;
  localparam int          FOD_MAIN_W    = 15;
  localparam int          FOD_POST_W    = 10;

  typedef enum logic [2:0] {
    FOD_WIDEBAND,
    FOD_SINC4,
    FOD_SINC4_SINC1,
    FOD_SINC3,
    FOD_SINC3_SINC1
  } fod_mode_e;

  typedef struct packed {
    fod_mode_e                mode;
    logic [FOD_MAIN_W-1:0]    osr_main;
    logic [FOD_POST_W-1:0]    osr_post;
  } fod_filt_s;

endpackage

// *** logic/fod_osr_decode.sv ***
`timescale 1ns/1ns
module fod_osr_decode
  import fod_pkg::*;
(
  input  wire logic [FOD_FILT_W-1:0] code,
  output fod_filt_s                  cfg
);

  // ----------------------------------------------------------------
  // code to structure and oversampling_ratio table
  // ----------------------------------------------------------------
  // post ratio of 1 means no averaging stage
  always_comb
  begin
    cfg.mode     = FOD_WIDEBAND;
    cfg.osr_main = 15'h0020;
    cfg.osr_post = 10'h001;
    case (code)
      5'h00: cfg.osr_main = 15'h0020;
      5'h01: cfg.osr_main = 15'h0040;
      5'h02: cfg.osr_main = 15'h0080;
      5'h03: cfg.osr_main = 15'h0100;
      5'h04: cfg.osr_main = 15'h0200;
      5'h05: cfg.osr_main = 15'h0400;
      5'h06: cfg.osr_main = 15'h0800;
      5'h07: cfg.osr_main = 15'h1000;
      5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
      5'h0E, 5'h0F, 5'h10, 5'h11, 5'h12:
      begin
        cfg.mode = FOD_SINC4;
        case (code)
          5'h08:   cfg.osr_main = 15'h000C;
          5'h09:   cfg.osr_main = 15'h0010;
          5'h0A:   cfg.osr_main = 15'h0018;
          5'h0B:   cfg.osr_main = 15'h0020;
          5'h0C:   cfg.osr_main = 15'h0040;
          5'h0D:   cfg.osr_main = 15'h0080;
          5'h0E:   cfg.osr_main = 15'h0100;
          5'h0F:   cfg.osr_main = 15'h0200;
          5'h10:   cfg.osr_main = 15'h0400;
          5'h11:   cfg.osr_main = 15'h0800;
          default: cfg.osr_main = 15'h1000;
        endcase
      end
      5'h1C:
      begin
        cfg.mode     = FOD_SINC3;
        cfg.osr_main = 15'h682B;
      end
      5'h1D:
      begin
        cfg.mode     = FOD_SINC3;
        cfg.osr_main = 15'h7D00;
      end
      5'h1E, 5'h1F:
      begin
        cfg.mode     = FOD_SINC3_SINC1;
        cfg.osr_main = 15'h7D00;
        cfg.osr_post = code[0] ? 10'h005 : 10'h003;
      end
      default:
      begin
        cfg.mode     = FOD_SINC4_SINC1;
        cfg.osr_main = 15'h0020;
        case (code)
          5'h13:   cfg.osr_post = 10'h002;
          5'h14:   cfg.osr_post = 10'h004;
          5'h15:   cfg.osr_post = 10'h00A;
          5'h16:   cfg.osr_post = 10'h014;
          5'h17:   cfg.osr_post = 10'h028;
          5'h18:   cfg.osr_post = 10'h064;
          5'h19:   cfg.osr_post = 10'h0C8;
          5'h1A:   cfg.osr_post = 10'h190;
          default: cfg.osr_post = 10'h3E8;
        endcase
      end
    endcase
  end

endmodule

// *** logic/fod_mod_clock.sv ***
`timescale 1ns/1ns
module fod_mod_clock
  import fod_pkg::*;
#(
  parameter int INT_DIV = FOD_INT_DIV
)(
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic ext_pin,
  input  wire logic ext_sel,
  input  wire logic div8,
  output logic      mod_en
);

  logic [1:0] ext_sync;
  logic       ext_last;
  logic [2:0] ext_cnt;
  logic [7:0] int_cnt;
  logic       ext_rise;

  // ----------------------------------------------------------------
  // external clock pin, synchronised then edge detected
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ext_sync <= 2'h0;
      ext_last <= 1'b0;
    end
    else
    begin
      ext_sync <= {ext_sync[0], ext_pin};
      ext_last <= ext_sync[1];
    end
  end

  assign ext_rise = ext_sync[1] & ~ext_last;

  // divide by eight counts external rising edges only
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ext_cnt <= 3'h0;
    else if (ext_rise)
      ext_cnt <= ext_cnt + 3'h1;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      int_cnt <= 8'h00;
    else if (int_cnt == 8'(INT_DIV - 1))
      int_cnt <= 8'h00;
    else
      int_cnt <= int_cnt + 8'h01;
  end

  always_comb
  begin
    if (!ext_sel)
      mod_en = (int_cnt == 8'h00);
    else if (div8)
      mod_en = ext_rise && (ext_cnt == 3'(FOD_EXT_DIV - 1));
    else
      mod_en = ext_rise;
  end

endmodule

// *** sim/fod_filter_cfg_sva.sv ***
`timescale 1ns/1ns
module fod_filter_cfg_sva
  import fod_pkg::*;
(
  input wire logic                  CLOCK,
  input wire logic                  RESETN,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [FOD_ADDR_W-1:0] PADDR,
  input wire logic [FOD_DATA_W-1:0] PWDATA,
  input wire logic [3:0]            PSTRB,
  input wire logic [FOD_DATA_W-1:0] PRDATA,
  input wire logic                  PSLVERR,
  input fod_filt_s                  FILTER_CFG,
  input wire logic [FOD_DLY_W-1:0]  START_DELAY,
  input wire logic                  CONV_16BIT,
  input wire logic                  STATUS_BYTE_EN,
  input wire logic                  SERIAL_CRC_EN,
  input wire logic                  CRC_APPEND,
  input wire logic                  REG_CRC_EN,
  input wire logic                  OUTPUT_DRIVE_STRENGTH,
  input wire logic                  CLK_EXT_SEL,
  input wire logic                  CLK_DIV8
);
  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire acc     = PSEL && PENABLE;
  wire wr_base = acc && PWRITE && PSTRB[0];
  wire wr_clk  = wr_base && PADDR == 8'h20;
  wire wr_filt = wr_base && PADDR == 8'h1C;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_clk_src_map: assert property (wr_clk |=>
    CLK_EXT_SEL == $past(PWDATA[7]) && CLK_DIV8 == $past(PWDATA[6]))
    else $error("clock select or divider not taken from write");
  a_res_map: assert property (wr_clk |=>
    CONV_16BIT == $past(PWDATA[3]))
    else $error("resolution level not taken from write");
  a_drive_stat_map: assert property (wr_clk |=>
    OUTPUT_DRIVE_STRENGTH == $past(PWDATA[5]) &&
    STATUS_BYTE_EN == $past(PWDATA[0]))
    else $error("drive or status enable not taken from write");
  a_crc_en_map: assert property (wr_clk |=>
    SERIAL_CRC_EN == $past(PWDATA[2]) && REG_CRC_EN == $past(PWDATA[1]))
    else $error("check enables not taken from write");
  a_append_tie: assert property (CRC_APPEND == SERIAL_CRC_EN)
    else $error("check byte append differs from enable");
  a_clk_reg_hold: assert property (!wr_clk |=>
    $stable({CLK_EXT_SEL, CLK_DIV8, CONV_16BIT, SERIAL_CRC_EN}))
    else $error("clock register level moved without write");
  a_reserved_zero: assert property (acc && !PWRITE &&
    PADDR == 8'h20 |-> PRDATA[4] == 1'b0 && PRDATA[31:8] == 24'h0)
    else $error("reserved bit of clock register read nonzero");
  a_delay_map: assert property (wr_filt |=>
    START_DELAY == $past(PWDATA[7:5]))
    else $error("start delay not taken from write");
  a_wide_decode: assert property (wr_filt && PWDATA[4:3] == 2'b00
    |-> ##2 FILTER_CFG.mode == FOD_WIDEBAND && FILTER_CFG.osr_post == 10'h1
    && FILTER_CFG.osr_main == (15'h20 << $past(PWDATA[2:0], 2)))
    else $error("wideband code decoded wrongly");
  a_sinc3_lone: assert property (wr_filt && PWDATA[4:1] == 4'hE
    |-> ##2 FILTER_CFG.mode == FOD_SINC3 && FILTER_CFG.osr_post == 10'h1)
    else $error("lone third order code decoded wrongly");
  a_align_err: assert property (acc && PADDR[1:0] != 2'b00
    |-> PSLVERR && PRDATA == 32'h0)
    else $error("unaligned access not refused");
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
  import fod_pkg::*;
;
  localparam int INT_DIV = 2;
  logic        CLOCK = 1'b0;
  logic        RESETN;
  logic        PSEL, PENABLE, PWRITE, EXT_CLK, CRC_CHECK;
  logic [7:0]  PADDR, CRC_RX, CRC_CALC, v;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0]  PSTRB;
  logic [23:0] SAMPLE_IN, CONV_DATA;
  logic [2:0]  START_DELAY;
  logic [7:0]  STATUS_BYTE;
  logic        PREADY, PSLVERR, MOD_EN, DATA_READY, CONV_16BIT, er;
  logic        STATUS_BYTE_EN, SERIAL_CRC_EN, CRC_APPEND, REG_CRC_EN;
  logic        OUTPUT_DRIVE_STRENGTH, CLK_EXT_SEL, CLK_DIV8;
  fod_filt_s   FILTER_CFG;
  int          miscompares = 0;
  int          num_checks = 0;
  int          mod_cnt = 0;
  int          n;
  int          s4 [11] = '{12, 16, 24, 32, 64, 128, 256, 512, 1024, 2048, 4096};
  int          s1 [9] = '{2, 4, 10, 20, 40, 100, 200, 400, 1000};

  fod_filter_cfg #(.INT_DIV(INT_DIV)) uut (
    .CLOCK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
    .PRDATA, .PREADY, .PSLVERR, .EXT_CLK, .SAMPLE_IN, .CRC_CHECK, .CRC_RX,
    .CRC_CALC, .FILTER_CFG, .START_DELAY, .MOD_EN, .DATA_READY, .CONV_DATA,
    .CONV_16BIT, .STATUS_BYTE, .STATUS_BYTE_EN, .SERIAL_CRC_EN, .CRC_APPEND,
    .REG_CRC_EN, .OUTPUT_DRIVE_STRENGTH, .CLK_EXT_SEL, .CLK_DIV8
  );

  always #5 CLOCK = ~CLOCK;
  always @(negedge CLOCK)
    if (MOD_EN === 1'b1)
      mod_cnt++;

  // ----------------------------------------------------------------
  // reference decode: {mode, main ratio, post ratio}
  // ----------------------------------------------------------------
  function automatic logic [27:0] ref_dec(input int c);
    if (c < 8)
      return {3'h0, 15'(32 << c), 10'h1};
    if (c < 19)
      return {3'h1, 15'(s4[c-8]), 10'h1};
    if (c < 28)
      return {3'h2, 15'h20, 10'(s1[c-19])};
    if (c < 30)
      return {3'h3, c == 28 ? 15'h682B : 15'h7D00, 10'h1};
    return {3'h4, 15'h7D00, c == 30 ? 10'h3 : 10'h5};
  endfunction

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // one idle cycle precedes each setup, so no signal is driven twice
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do
      @(posedge CLOCK);
    while (PREADY !== 1'b1 && ++k < 20);
    if (k >= 20)
    begin
      miscompares++;
      wrap_up();
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, {24'h0, d}, 4'hF);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(a, 1'b0, 32'h0, 4'hF);
    chk(nm, e, rd);
  endtask

  task automatic crc_pulse(input logic [7:0] a, b);
    @(posedge CLOCK);
    CRC_RX <= a;
    CRC_CALC <= b;
    CRC_CHECK <= 1'b1;
    @(posedge CLOCK);
    CRC_CHECK <= 1'b0;
  endtask

  task automatic wait_dr();
    n = 1;
    do
      @(negedge CLOCK);
    while (DATA_READY !== 1'b1 && ++n < 1000);
    if (n >= 1000)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic ext_run(input int k);
    mod_cnt = 0;
    repeat (k)
    begin
      EXT_CLK <= 1'b1;
      repeat (3) @(posedge CLOCK);
      EXT_CLK <= 1'b0;
      repeat (3) @(posedge CLOCK);
    end
    repeat (8) @(posedge CLOCK);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {RESETN, PSEL, PENABLE, PWRITE, EXT_CLK, CRC_CHECK} = 6'h0;
    {PADDR, PWDATA, PSTRB, SAMPLE_IN, CRC_RX, CRC_CALC} = '0;
    void'($urandom(32'hCDEB));
    repeat (4) @(posedge CLOCK);
    RESETN <= 1'b1;
    repeat (2) @(posedge CLOCK);
    chk("cfg_rst", ref_dec(0), FILTER_CFG);
    rdc("filt_rst", 8'h1C, 32'h0);
    rdc("clk_rst", 8'h20, 32'h0);
    for (int c = 0; c < 32; c++)
    begin
      v = {3'($urandom), 5'(c)};
      wr(8'h1C, v);
      repeat (2) @(negedge CLOCK);
      chk("filter_cfg", ref_dec(c), FILTER_CFG);
      chk("start_delay", v[7:5], START_DELAY);
      rdc("filt_reg", 8'h1C, v);
      rdc("filt_stat", 8'h40, ref_dec(c));
    end
    repeat (8)
    begin
      v = 8'($urandom);
      wr(8'h20, v);
      @(negedge CLOCK);
      chk("clk_outs", {v[7:5], v[3:0]},
        {CLK_EXT_SEL, CLK_DIV8, OUTPUT_DRIVE_STRENGTH, CONV_16BIT,
         SERIAL_CRC_EN, REG_CRC_EN, STATUS_BYTE_EN});
      rdc("clk_reg", 8'h20, v & 8'hEF);
    end
    wr(8'h20, 8'h00);
    apb(8'h20, 1'b1, 32'hFF, 4'h0);
    apb(8'h21, 1'b1, 32'hFF, 4'hF);
    chk("unaligned_err", 32'h1, er);
    apb(8'h24, 1'b0, 32'h0, 4'hF);
    chk("unmapped_err", 32'h1, er);
    chk("unmapped_rd", 32'h0, rd);
    rdc("clk_keep", 8'h20, 32'h0);
    wr(8'h1C, 8'h00);
    wr(8'h20, 8'h04);
    crc_pulse(8'h3C, 8'h3C);
    rdc("err_match", 8'h44, 32'h0);
    crc_pulse(8'h5A, 8'hA5);
    rdc("err_set", 8'h44, 32'h1);
    wait_dr();
    chk("status_err", 32'h01, STATUS_BYTE);
    wr(8'h44, 8'h01);
    rdc("err_clr", 8'h44, 32'h0);
    wr(8'h20, 8'h08);
    crc_pulse(8'h5A, 8'hA5);
    rdc("err_off", 8'h44, 32'h0);
    SAMPLE_IN <= 24'($urandom);
    wait_dr();
    wait_dr();
    chk("frame_len", 32 * INT_DIV, n);
    chk("conv_16", {SAMPLE_IN[23:8], 8'h00}, CONV_DATA);
    wr(8'h20, 8'h00);
    wait_dr();
    chk("conv_24", SAMPLE_IN, CONV_DATA);
    wr(8'h20, 8'h80);
    repeat (8) @(posedge CLOCK);
    ext_run(32);
    chk("ext_rate", 32'd32, mod_cnt);
    wr(8'h20, 8'hC0);
    repeat (8) @(posedge CLOCK);
    ext_run(64);
    chk("ext_div8", 32'h8, mod_cnt);
    wr(8'h1C, 8'hFF);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RESETN <= 1'b1;
    rdc("clk_rst2", 8'h20, 32'h0);
    rdc("filt_rst2", 8'h1C, 32'h0);
    chk("cfg_rst2", ref_dec(0), FILTER_CFG);
    wrap_up();
  end

  // a hang is cut short well past the roughly 1350 cycles needed
  initial
  begin
    #500000;
    miscompares++;
    wrap_up();
  end
endmodule

bind fod_filter_cfg fod_filter_cfg_sva u_sva (
  .CLOCK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
  .PRDATA, .PSLVERR, .FILTER_CFG, .START_DELAY, .CONV_16BIT,
  .STATUS_BYTE_EN, .SERIAL_CRC_EN, .CRC_APPEND, .REG_CRC_EN,
  .OUTPUT_DRIVE_STRENGTH, .CLK_EXT_SEL, .CLK_DIV8
);
